//--- shared/fault_status_defines.vh
// Constants for the latched fault/warning status register bank.
// Assumes a byte-wide command/data port from the bus interface logic.
// Function
// - Output overvoltage fault latched in bit 7, masked per source by extension mask.
// - Output overvoltage warning latched in bit 6, mask covers fixed and tracking.
// - Output undervoltage warning bit 5, undervoltage fault bit 4, read 1 once seen.
// - Setpoint clamp latched in bit 3, turn-on timeout in bit 2.
// - Unsupported bit positions are read-only and read zero, except the live input-off bit 3.
// - Flags clear on global clear-faults or on writing 1 to their bit.
// - Current, input, temperature status at codes 7Bh, 7Ch, 7Dh, byte access.
// - Overcurrent fault bit 7, overcurrent warning bit 5, undercurrent fault bit 4.
// - Input overvoltage fault bit 7, input overvoltage warning bit 6.
// - Input undervoltage warning latched in bit 5 and may raise the alert.
// - Input bit 3 is live: 0 when input on, 1 when off.
// - Input-off set when input below turn-on or aux supply low; never alerts.
// - Input-off asserted after reset without raising the alert.
// - Input undervoltage warning suppressed until input first exceeds turn-on threshold.
// - Overtemperature fault bit 7, warning bit 6, other six bits zero.
// - Every alert-capable bit has a mask bit; alert only for unmasked events.
// - Output-voltage status served at code 7Ah with byte read and write.
// - Summary bits are OR of each status register's flags, cleared with them.
`ifndef FAULT_STATUS_DEFINES_VH
`define FAULT_STATUS_DEFINES_VH
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_ALERT_MASK 8'h1B
`define CMD_ALERT_MASK_EXT 8'hF0
`define CMD_OUT_VOLT_STATUS 8'h7A
`define CMD_OUT_CURR_STATUS 8'h7B
`define CMD_IN_VOLT_STATUS 8'h7C
`define CMD_TEMP_STATUS 8'h7D
`define OUT_VOLT_SUPPORTED 8'hFC
`define OUT_CURR_SUPPORTED 8'hB0
`define IN_VOLT_SUPPORTED 8'hE0
`define TEMP_SUPPORTED 8'hC0
`define LIVE_INPUT_OFF_BIT 3
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00
`define EXT_MASK_RESET 8'h00
`define IDX_OUT_VOLT 2'd0
`define IDX_OUT_CURR 2'd1
`define IDX_IN_VOLT 2'd2
`define IDX_TEMP 2'd3
`endif

//--- hw/flag_byte.v
// One byte of latched status flags with write-one-to-clear.
// Assumes event inputs are synchronous single-cycle or level detections.
`include "fault_status_defines.vh"
module flag_byte #(
   parameter [7:0] SUPPORTED = 8'hFF
) (
   input wire ref_clk,
   input wire rst,
   input wire [7:0] event_in,
   input wire [7:0] w1c_bits,
   input wire clear_all,
   output reg [7:0] flags_r
);
   wire [7:0] clr_bits;
   wire [7:0] flags_nxt;
   assign clr_bits = clear_all ? 8'hFF : w1c_bits;
   // Set wins over clear; unsupported bits held at zero
   assign flags_nxt = ((flags_r & ~clr_bits) | event_in) & SUPPORTED;
   // Flag register
   always @(posedge ref_clk)
   begin
      if (rst)
         flags_r <= `STATUS_RESET;
      else
         flags_r <= flags_nxt;
   end
endmodule

//--- hw/status_reg_file.v
// Small register memory holding the alert mask bytes, registered read.
// Assumes one write port and one read port on the same clock.
`include "fault_status_defines.vh"
module status_reg_file (
   input wire ref_clk,
   input wire rst,
   input wire wr_en,
   input wire wr_sel,
   input wire [7:0] wr_data,
   output reg [7:0] mask_r,
   output reg [7:0] ext_mask_r
);
   // Mask storage, both bytes readable directly
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         mask_r <= `MASK_RESET;
         ext_mask_r <= `EXT_MASK_RESET;
      end
      else if (wr_en)
      begin
         if (wr_sel)
            ext_mask_r <= wr_data;
         else
            mask_r <= wr_data;
      end
   end
endmodule

//--- hw/fault_status_bank.v
// Latched fault and warning status registers with byte command access and alert.
// Assumes a bus interface that presents decoded byte reads/writes as pulses.
`include "fault_status_defines.vh"
module fault_status_bank (
   input wire ref_clk,
   input wire rst,
   input wire [7:0] cmd_code,
   input wire cmd_wr,
   input wire cmd_rd,
   input wire [7:0] wr_data,
   input wire ov_fixed_fault,
   input wire ov_track_fault,
   input wire ov_prebias_fault,
   input wire ov_fixed_warn,
   input wire ov_track_warn,
   input wire out_uv_warn,
   input wire out_uv_fault,
   input wire setpoint_clamp,
   input wire turn_on_timeout,
   input wire oc_fault,
   input wire oc_warn,
   input wire uc_fault,
   input wire in_ov_fault,
   input wire in_ov_warn,
   input wire in_uv_warn,
   input wire power_input_rail_above_on,
   input wire aux_five_volt_supply_ok,
   input wire ot_fault,
   input wire ot_warn,
   output reg [7:0] rd_data_r,
   output reg rd_valid_r,
   output reg alert_r,
   output reg [3:0] summary_r
);
   localparam ST_IDLE = 2'b01;
   localparam ST_READ = 2'b10;
   reg [1:0] state_r;
   reg input_seen_on_r;
   reg [7:0] ov_ev;
   reg [7:0] oc_ev;
   reg [7:0] in_ev;
   reg [7:0] tp_ev;
   reg [7:0] rd_nxt;
   reg [1:0] alert_src_r;
   wire [7:0] ov_flags;
   wire [7:0] oc_flags;
   wire [7:0] in_flags;
   wire [7:0] tp_flags;
   wire [7:0] mask;
   wire [7:0] ext_mask;
   wire clear_all;
   wire input_off;
   wire [7:0] in_read;
   wire ov_src_unmasked;
   wire ovw_src_unmasked;
   wire alert_nxt;
   wire [31:0] w1c_all;

   // Command decode to register index, one bit per status byte
   function [3:0] sel_of;
      input [7:0] code;
      begin
         case (code)
            `CMD_OUT_VOLT_STATUS: sel_of = 4'h1;
            `CMD_OUT_CURR_STATUS: sel_of = 4'h2;
            `CMD_IN_VOLT_STATUS: sel_of = 4'h4;
            `CMD_TEMP_STATUS: sel_of = 4'h8;
            default: sel_of = 4'h0;
         endcase
      end
   endfunction

   assign clear_all = cmd_wr && (cmd_code == `CMD_CLEAR_FAULTS);
   assign input_off = ~power_input_rail_above_on | ~aux_five_volt_supply_ok;

   // Event bit placement per status byte
   always @*
   begin
      ov_ev = 8'h00;
      oc_ev = 8'h00;
      in_ev = 8'h00;
      tp_ev = 8'h00;
      ov_ev[7] = ov_fixed_fault | ov_track_fault | ov_prebias_fault;
      ov_ev[6] = ov_fixed_warn | ov_track_warn;
      ov_ev[5] = out_uv_warn;
      ov_ev[4] = out_uv_fault;
      ov_ev[3] = setpoint_clamp;
      ov_ev[2] = turn_on_timeout;
      oc_ev[7] = oc_fault;
      oc_ev[5] = oc_warn;
      oc_ev[4] = uc_fault;
      in_ev[7] = in_ov_fault;
      in_ev[6] = in_ov_warn;
      in_ev[5] = in_uv_warn & input_seen_on_r;
      tp_ev[7] = ot_fault;
      tp_ev[6] = ot_warn;
   end

   // Remembers the input having crossed the turn-on threshold once
   always @(posedge ref_clk)
   begin
      if (rst)
         input_seen_on_r <= 1'b0;
      else if (power_input_rail_above_on)
         input_seen_on_r <= 1'b1;
   end

   // Write-one-to-clear strobes, one byte per status register
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : w1c_gen
         assign w1c_all[g*8 +: 8] = (cmd_wr && sel_of(cmd_code) == (4'h1 << g)) ?
            wr_data : 8'h00;
      end
   endgenerate

   flag_byte #(.SUPPORTED(`OUT_VOLT_SUPPORTED)) u_out_volt (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_in(ov_ev),
      .w1c_bits(w1c_all[7:0]),
      .clear_all(clear_all),
      .flags_r(ov_flags)
   );
   flag_byte #(.SUPPORTED(`OUT_CURR_SUPPORTED)) u_out_curr (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_in(oc_ev),
      .w1c_bits(w1c_all[15:8]),
      .clear_all(clear_all),
      .flags_r(oc_flags)
   );
   flag_byte #(.SUPPORTED(`IN_VOLT_SUPPORTED)) u_in_volt (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_in(in_ev),
      .w1c_bits(w1c_all[23:16]),
      .clear_all(clear_all),
      .flags_r(in_flags)
   );
   flag_byte #(.SUPPORTED(`TEMP_SUPPORTED)) u_temp (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_in(tp_ev),
      .w1c_bits(w1c_all[31:24]),
      .clear_all(clear_all),
      .flags_r(tp_flags)
   );

   status_reg_file u_masks (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(cmd_wr && (cmd_code == `CMD_ALERT_MASK || cmd_code == `CMD_ALERT_MASK_EXT)),
      .wr_sel(cmd_code == `CMD_ALERT_MASK_EXT),
      .wr_data(wr_data),
      .mask_r(mask),
      .ext_mask_r(ext_mask)
   );

   // Live input-off bit merged into the input byte on read
   assign in_read = in_flags | ({7'h00, input_off} << `LIVE_INPUT_OFF_BIT);

   // Per-source alert gating for output overvoltage sources
   assign ov_src_unmasked = (ov_fixed_fault & ~ext_mask[0]) |
      (ov_track_fault & ~ext_mask[1]) | (ov_prebias_fault & ~ext_mask[2]);
   assign ovw_src_unmasked = (ov_fixed_warn & ~ext_mask[3]) |
      (ov_track_warn & ~ext_mask[4]);

   // Alert source latch for overvoltage, cleared with its flag
   always @(posedge ref_clk)
   begin
      if (rst)
         alert_src_r <= 2'h0;
      else
      begin
         alert_src_r[0] <= ov_src_unmasked | (alert_src_r[0] & ov_flags[7]);
         alert_src_r[1] <= ovw_src_unmasked | (alert_src_r[1] & ov_flags[6]);
      end
   end

   // Alert: every flag has a mask bit; live input-off never contributes
   assign alert_nxt = (alert_src_r[0] & ov_flags[7] & ~mask[7]) |
      (alert_src_r[1] & ov_flags[6] & ~mask[6]) |
      (|(ov_flags[5:2] & ~mask[5:2])) |
      (|(oc_flags & ~{mask[7], 1'b1, mask[5:4], 4'hF})) |
      (|(in_flags & ~{mask[7:5], 5'h1F})) |
      (|(tp_flags & ~{mask[7:6], 6'h3F}));

   // Read mux
   always @*
   begin
      case (sel_of(cmd_code))
         4'h1: rd_nxt = ov_flags;
         4'h2: rd_nxt = oc_flags;
         4'h4: rd_nxt = in_read;
         4'h8: rd_nxt = tp_flags;
         4'h0:
         begin
            if (cmd_code == `CMD_ALERT_MASK)
               rd_nxt = mask;
            else if (cmd_code == `CMD_ALERT_MASK_EXT)
               rd_nxt = ext_mask;
            else
               rd_nxt = 8'h00;
         end
         default: rd_nxt = 8'h00;
      endcase
   end

   // Read handshake state machine, one-cycle valid answer
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         rd_data_r <= 8'h00;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               rd_valid_r <= 1'b0;
               if (cmd_rd)
               begin
                  rd_data_r <= rd_nxt;
                  rd_valid_r <= 1'b1;
                  state_r <= ST_READ;
               end
            end
            ST_READ:
            begin
               rd_valid_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            default:
            begin
               rd_valid_r <= 1'b0;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Alert and summary outputs registered
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         alert_r <= 1'b0;
         summary_r <= 4'h0;
      end
      else
      begin
         alert_r <= alert_nxt;
         summary_r <= {|ov_flags, |oc_flags, |in_flags, |tp_flags};
      end
   end
endmodule

//--- verif/fault_status_sva.sv
// Assertions on the status bank ports.
// Assumes one clock, ref_clk, and a synchronous active-high rst.
module fault_status_sva (
   input wire ref_clk,
   input wire rst,
   input wire [7:0] cmd_code,
   input wire cmd_wr,
   input wire cmd_rd,
   input wire [7:0] wr_data,
   input wire oc_fault,
   input wire oc_warn,
   input wire uc_fault,
   input wire ot_fault,
   input wire power_input_rail_above_on,
   input wire aux_five_volt_supply_ok,
   input wire [7:0] rd_data_r,
   input wire rd_valid_r,
   input wire alert_r,
   input wire [3:0] summary_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // Input off while the rail or the aux supply is low
   wire live_off = !(power_input_rail_above_on && aux_five_volt_supply_ok);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Read taken, then answered for one cycle
   sequence s_rd_take;
      cmd_rd && !rd_valid_r;
   endsequence
   sequence s_rd_answer;
      rd_valid_r ##1 !rd_valid_r;
   endsequence
   AST_RD_ANSWER: assert property (s_rd_take |=> s_rd_answer)
      else $error("read not answered in one cycle");
   AST_RD_NONE: assert property (!cmd_rd |=> !rd_valid_r)
      else $error("read data valid without a read");
   AST_IOUT_ZERO: assert property (rd_valid_r && $past(cmd_code) == 8'h7B |->
      (rd_data_r & 8'h4F) == 8'h00) else $error("current status spare bits set");
   AST_TEMP_ZERO: assert property (rd_valid_r && $past(cmd_code) == 8'h7D |->
      (rd_data_r & 8'h3F) == 8'h00) else $error("temperature spare bits set");
   AST_LIVE: assert property (rd_valid_r && $past(cmd_code) == 8'h7C &&
      $past(live_off) == $past(live_off, 2) |-> rd_data_r[3] == $past(live_off))
      else $error("input off bit wrong");
   AST_OC_LATCH: assert property (oc_fault |-> ##2 summary_r[2])
      else $error("overcurrent not latched");
   AST_SET_WINS: assert property (ot_fault && cmd_wr && cmd_code == 8'h03 |->
      ##2 summary_r[0]) else $error("event lost under clear");
   AST_W1C: assert property (cmd_wr && cmd_code == 8'h7B && (wr_data & 8'hB0) == 8'hB0 &&
      !oc_fault && !oc_warn && !uc_fault |-> ##2 !summary_r[2])
      else $error("current flags not cleared");
   AST_ALERT_CAUSE: assert property (alert_r |-> summary_r != 4'h0)
      else $error("alert without latched flag");
endmodule

bind fault_status_bank fault_status_sva chk (.ref_clk, .rst, .cmd_code, .cmd_wr, .cmd_rd,
   .wr_data, .oc_fault, .oc_warn, .uc_fault, .ot_fault, .power_input_rail_above_on,
   .aux_five_volt_supply_ok, .rd_data_r, .rd_valid_r, .alert_r, .summary_r);

//--- verif/fs_host.sv
// Host model issuing single-byte reads and writes to the status bank.
// Assumes the bank answers a read the cycle after it is taken.
module fs_host (
   input wire ref_clk,
   output logic [7:0] cmd_code,
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] wr_data,
   input wire [7:0] rd_data_r,
   input wire rd_valid_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      cmd_code = 8'h00;
      cmd_wr = 1'h0;
      cmd_rd = 1'h0;
      wr_data = 8'h00;
   end
   // Byte write held to the taking edge, then fields scrambled
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      @(posedge ref_clk);
      cmd_code <= c;
      wr_data <= d;
      cmd_wr <= 1'h1;
      @(posedge ref_clk);
      cmd_wr <= 1'h0;
      cmd_code <= ~c;
      wr_data <= ~d;
   endtask
   // Byte read held until the edge that sees the answer, taken there
   task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic ok);
      @(posedge ref_clk);
      cmd_code <= c;
      cmd_rd <= 1'h1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      d = rd_data_r;
      ok = rd_valid_r;
      cmd_rd <= 1'h0;
      cmd_code <= ~c;
   endtask
endmodule

//--- verif/tb_fault_status_bank.sv
// Testbench for the status bank: host byte calls with expected values.
// Assumes fs_host as the bus partner and event levels driven here.
module tb_fault_status_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [16:0] ev = 17'h00000;
   logic pwr_on = 1'h0;
   logic aux_ok = 1'h1;
   wire [7:0] cmd_code, wr_data, rd_data_r;
   wire cmd_wr, cmd_rd, rd_valid_r, alert_r;
   wire [3:0] summary_r;
   int bad_count = 0;
   int total_checks = 0;
   fs_host host (.ref_clk(ref_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .wr_data(wr_data), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));
   fault_status_bank dut (.ref_clk(ref_clk), .rst(rst), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .wr_data(wr_data), .ov_fixed_fault(ev[0]), .ov_track_fault(ev[1]),
      .ov_prebias_fault(ev[2]), .ov_fixed_warn(ev[3]), .ov_track_warn(ev[4]),
      .out_uv_warn(ev[5]), .out_uv_fault(ev[6]), .setpoint_clamp(ev[7]),
      .turn_on_timeout(ev[8]), .oc_fault(ev[9]), .oc_warn(ev[10]), .uc_fault(ev[11]),
      .in_ov_fault(ev[12]), .in_ov_warn(ev[13]), .in_uv_warn(ev[14]),
      .power_input_rail_above_on(pwr_on), .aux_five_volt_supply_ok(aux_ok),
      .ot_fault(ev[15]), .ot_warn(ev[16]), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
      .alert_r(alert_r), .summary_r(summary_r));
   // 100 MHz clock
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // Byte comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Read a register and compare it
   task automatic rdc(input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.rd(c, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d, exp);
   endtask
   // One-cycle event pulse
   task automatic pulse(input logic [16:0] v);
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= 17'h00000;
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   // Counts, verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 110 cycles
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      bad_count++;
      results();
   end
   // Test sequence
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      rdc(8'h7A, 8'h00);
      rdc(8'h7B, 8'h00);
      rdc(8'h7C, 8'h08);
      rdc(8'h7D, 8'h00);
      chk({7'h00, alert_r}, 8'h00);
      note("reset");
      pulse(17'h1FFFF);
      rdc(8'h7A, 8'hFC);
      rdc(8'h7B, 8'hB0);
      rdc(8'h7C, 8'hC8);
      rdc(8'h7D, 8'hC0);
      chk({7'h00, alert_r}, 8'h01);
      chk({4'h0, summary_r}, 8'h0F);
      note("latch");
      host.wr(8'h7B, 8'h80);
      rdc(8'h7B, 8'h30);
      host.wr(8'h7A, 8'h00);
      rdc(8'h7A, 8'hFC);
      host.wr(8'h7B, 8'hFF);
      rdc(8'h7B, 8'h00);
      @(posedge ref_clk);
      ev <= 17'h08000;
      host.wr(8'h03, 8'h00);
      ev <= 17'h00000;
      rdc(8'h7D, 8'h80);
      rdc(8'h7A, 8'h00);
      rdc(8'h7C, 8'h08);
      host.wr(8'h7D, 8'hC0);
      rdc(8'h7D, 8'h00);
      chk({7'h00, alert_r}, 8'h00);
      chk({4'h0, summary_r}, 8'h00);
      note("clear");
      @(posedge ref_clk);
      pwr_on <= 1'h1;
      rdc(8'h7C, 8'h00);
      pulse(17'h04000);
      rdc(8'h7C, 8'h20);
      aux_ok <= 1'h0;
      rdc(8'h7C, 8'h28);
      chk({7'h00, alert_r}, 8'h01);
      note("input");
      host.wr(8'h03, 8'h00);
      host.wr(8'h1B, 8'hFF);
      pulse(17'h08000);
      rdc(8'h7D, 8'h80);
      chk({7'h00, alert_r}, 8'h00);
      host.wr(8'h1B, 8'h00);
      host.wr(8'h03, 8'h00);
      host.wr(8'hF0, 8'h01);
      pulse(17'h00001);
      rdc(8'h7A, 8'h80);
      chk({7'h00, alert_r}, 8'h00);
      pulse(17'h00002);
      rdc(8'h7A, 8'h80);
      chk({7'h00, alert_r}, 8'h01);
      note("mask");
      rdc(8'h55, 8'h00);
      @(posedge ref_clk);
      ev <= 17'h00200;
      host.wr(8'h7B, 8'h80);
      rdc(8'h7B, 8'h80);
      ev <= 17'h00000;
      note("held");
      results();
   end
endmodule
